// [rtl/usm_defines.vh]
// Contract
// - Nothing starts until the enable bit is set.
// - A beat shifts from 1 up to 32 bits.
// - Per-entry length mode limits a beat to 1..24 bits.
// - Three independent active-low chip selects are driven.
// - Transmit and receive FIFOs hold 4 entries of 32 bits each.
// - Output edge and input sample edge are chosen independently.
// - Serial clock idle level is selectable high or low.
// - Shift-out and shift-in order selectable MSB or LSB first.
// - Select falls one and a half bit times before the first clock edge.
// - A half bit with still clock follows the last clock edge.
// - Optional extra half bit gives input a full bit time.
// - Select stays high one bit time plus 0..7 extra bit times.
// - Serial clock is system clock over 2*(speed+1).
// - Data out changes delayed by extra 0, 1, 4 or 7 cycles.
// - Two interrupt sources: transmit empty and idle.
// - Transmit-empty asserts once the last entry leaves the FIFO.
// - One received entry per transmitted entry, dropped while RX FIFO is full; no RX-full interrupt.
// - Idle needs empty TX FIFO, ended select-high time, data stored.
// - Bursts hold at most 32 bits; longer ones chain.
// - Hold address keeps select low; end address releases it.
// - Speed divider sits in control 0 bits 31:20.
// - Per-entry mode: bits 28:24 length, bits 23:0 data.
// - Extra select-high count sits in control 1 bits 10:8.
// - Each interrupt has its enable; line high while enabled cond holds.
`ifndef USM_DEFINES_VH
`define USM_DEFINES_VH

// ***************************************************
// Register byte addresses
// ***************************************************
`define USM_A_CNTL0 8'h00
`define USM_A_CNTL1 8'h04
`define USM_A_STAT 8'h08
`define USM_A_RXDATA 8'h0c
`define USM_A_TXEND 8'h10
`define USM_A_TXHOLD 8'h14

// ***************************************************
// Control 0 fields
// ***************************************************
`define USM_C0_SPEED 31:20
`define USM_C0_CS 19:17
`define USM_C0_POST 16
`define USM_C0_VCS 15
`define USM_C0_VW 14
`define USM_C0_HOLD 13:12
`define USM_C0_EN 11
`define USM_C0_INR 10
`define USM_C0_CLR 9
`define USM_C0_OUTR 8
`define USM_C0_INV 7
`define USM_C0_OMSB 6
`define USM_C0_LEN 5:0
`define USM_C0_RST 32'h000e0000

// ***************************************************
// Control 1 fields, status fields, TX word fields
// ***************************************************
`define USM_C1_CSHI 10:8
`define USM_C1_TXIE 7
`define USM_C1_DNIE 6
`define USM_C1_IMSB 1
`define USM_C1_MASK 32'h000007c2
`define USM_TX_CS 31:29
`define USM_TX_LEN 28:24
`define USM_TX_DATA 23:0
`define USM_ST_BUSY 0
`define USM_ST_TXE 1
`define USM_ST_TXF 2
`define USM_ST_RXE 3
`define USM_ST_RXF 4
`define USM_ST_TXLVL 10:8
`define USM_ST_RXLVL 14:12

// ***************************************************
// Sizes and counts
// ***************************************************
`define USM_DEPTH 4
`define USM_MAXLEN 6'd32
`define USM_VMAXLEN 6'd24
`define USM_VSHIFT 6'd8
`define USM_HOLD1 4'd1
`define USM_HOLD2 4'd4
`define USM_HOLD3 4'd7

`endif

// [rtl/usm_master.v]
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "usm_defines.vh"

module usm_master (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire MISO,
  output reg MOSI,
  output reg SERIAL_CLOCK_OUT,
  output reg [2:0] CS_N,
  output reg IRQ
);

  // ***************************************************
  // State codes
  // ***************************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SETUP = 3'd1;
  localparam [2:0] ST_SHIFT = 3'd2;
  localparam [2:0] ST_TAIL = 3'd3;
  localparam [2:0] ST_CSHI = 3'd4;

  reg [31:0] cntl0_q;
  reg [31:0] cntl1_q;
  reg [32:0] tx_mem [0:`USM_DEPTH-1];
  reg [31:0] rx_mem [0:`USM_DEPTH-1];
  reg [1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  reg [2:0] tx_cnt_q, rx_cnt_q;
  reg [2:0] state_q;
  reg [11:0] div_q;
  reg [6:0] ph_q;
  reg [31:0] tsr_q;
  reg [31:0] rsr_q;
  reg [5:0] len_q;
  reg [2:0] cs_q;
  reg keep_q;
  reg first_in_q;
  reg pend_q;
  reg [3:0] hcnt_q;

  // ***************************************************
  // Bus decode
  // ***************************************************
  wire acc = PSEL & PENABLE & PREADY;
  wire wr = acc & PWRITE;
  wire rd = acc & ~PWRITE;
  wire known = (PADDR == `USM_A_CNTL0) | (PADDR == `USM_A_CNTL1) |
               (PADDR == `USM_A_STAT) | (PADDR == `USM_A_RXDATA) |
               (PADDR == `USM_A_TXEND) | (PADDR == `USM_A_TXHOLD);
  wire clr = cntl0_q[`USM_C0_CLR];
  wire tx_full = (tx_cnt_q == `USM_DEPTH);
  wire tx_empty = (tx_cnt_q == 3'd0);
  wire rx_full = (rx_cnt_q == `USM_DEPTH);
  wire rx_empty = (rx_cnt_q == 3'd0);
  wire tx_push = wr & ~tx_full &
                 ((PADDR == `USM_A_TXEND) | (PADDR == `USM_A_TXHOLD));
  wire rx_pop = rd & ~rx_empty & (PADDR == `USM_A_RXDATA);

  // ***************************************************
  // Timing helpers
  // ***************************************************
  wire [11:0] speed = cntl0_q[`USM_C0_SPEED];
  wire tick = (state_q != ST_IDLE) & (div_q == speed);
  wire lvl_new = ~SERIAL_CLOCK_OUT;
  wire out_edge = (lvl_new == cntl0_q[`USM_C0_OUTR]);
  wire in_edge = (lvl_new == cntl0_q[`USM_C0_INR]);
  wire post = cntl0_q[`USM_C0_POST];
  wire omsb = cntl0_q[`USM_C0_OMSB];
  wire imsb = cntl1_q[`USM_C1_IMSB];
  wire [6:0] shift_halves = {len_q, 1'b0};
  wire [6:0] tail_halves = post ? 7'd2 : 7'd1;
  wire [6:0] cshi_halves = {3'd0, cntl1_q[`USM_C1_CSHI], 1'b0} +
                           7'd2;
  wire [31:0] rx_next = imsb ? {rsr_q[30:0], MISO} : {MISO, rsr_q[31:1]};
  wire [31:0] rx_all = post ? rx_next : rsr_q;
  wire [5:0] rx_gap = `USM_MAXLEN - len_q;
  wire [31:0] rx_word = imsb ? rx_all : (rx_all >> rx_gap);
  wire [32:0] tx_head = tx_mem[tx_rp_q];

  // ***************************************************
  // Entry decode at start of a burst
  // ***************************************************
  reg [5:0] ld_len;
  reg [31:0] ld_data;
  reg [2:0] ld_cs;
  always @* begin
    ld_cs = cntl0_q[`USM_C0_CS];
    if (cntl0_q[`USM_C0_VW]) begin
      ld_len = {1'b0, tx_head[`USM_TX_LEN]};
      if (ld_len == 6'd0) begin
        ld_len = 6'd1;
      end
      if (ld_len > `USM_VMAXLEN) begin
        ld_len = `USM_VMAXLEN;
      end
      ld_data = {8'h00, tx_head[`USM_TX_DATA]};
      if (omsb) begin
        ld_data = ld_data << `USM_VSHIFT;
      end
      if (cntl0_q[`USM_C0_VCS]) begin
        ld_cs = tx_head[`USM_TX_CS];
      end
    end else begin
      ld_len = cntl0_q[`USM_C0_LEN];
      if (ld_len == 6'd0) begin
        ld_len = 6'd1;
      end
      if (ld_len > `USM_MAXLEN) begin
        ld_len = `USM_MAXLEN;
      end
      ld_data = tx_head[31:0];
      if (omsb) begin
        ld_data = tx_head[31:0] << (`USM_MAXLEN - ld_len);
      end
    end
  end

  wire start = (state_q == ST_IDLE) & cntl0_q[`USM_C0_EN] &
               ~tx_empty & ~clr;
  wire burst_end = (state_q == ST_TAIL) & tick &
                   (ph_q == tail_halves - 7'd1);

  // ***************************************************
  // Hold-time select
  // ***************************************************
  reg [3:0] hold;
  always @* begin
    case (cntl0_q[`USM_C0_HOLD])
      2'd1: hold = `USM_HOLD1;
      2'd2: hold = `USM_HOLD2;
      2'd3: hold = `USM_HOLD3;
      default: hold = 4'd0;
    endcase
  end

  // ***************************************************
  // APB registers and answer
  // ***************************************************
  always @(posedge CLK) begin
    if (RST) begin
      cntl0_q <= `USM_C0_RST;
      cntl1_q <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~known;
      if (wr & (PADDR == `USM_A_CNTL0)) begin
        cntl0_q <= PWDATA;
      end
      if (wr & (PADDR == `USM_A_CNTL1)) begin
        cntl1_q <= PWDATA & `USM_C1_MASK;
      end
      if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
        case (PADDR)
          `USM_A_CNTL0: PRDATA <= cntl0_q;
          `USM_A_CNTL1: PRDATA <= cntl1_q;
          `USM_A_STAT: begin
            PRDATA <= 32'h00000000;
            PRDATA[`USM_ST_BUSY] <= (state_q != ST_IDLE);
            PRDATA[`USM_ST_TXE] <= tx_empty;
            PRDATA[`USM_ST_TXF] <= tx_full;
            PRDATA[`USM_ST_RXE] <= rx_empty;
            PRDATA[`USM_ST_RXF] <= rx_full;
            PRDATA[`USM_ST_TXLVL] <= tx_cnt_q;
            PRDATA[`USM_ST_RXLVL] <= rx_cnt_q;
          end
          `USM_A_RXDATA: PRDATA <= rx_mem[rx_rp_q];
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // ***************************************************
  // Transmit and receive FIFOs
  // ***************************************************
  always @(posedge CLK) begin
    if (RST | clr) begin
      tx_wp_q <= 2'd0;
      tx_rp_q <= 2'd0;
      tx_cnt_q <= 3'd0;
      rx_wp_q <= 2'd0;
      rx_rp_q <= 2'd0;
      rx_cnt_q <= 3'd0;
    end else begin
      // TX: write from bus, read at burst start
      if (tx_push) begin
        tx_mem[tx_wp_q] <= {PADDR == `USM_A_TXHOLD, PWDATA};
        tx_wp_q <= tx_wp_q + 2'd1;
      end
      if (start) begin
        tx_rp_q <= tx_rp_q + 2'd1;
      end
      tx_cnt_q <= tx_cnt_q + {2'd0, tx_push} - {2'd0, start};
      // RX: one entry per burst, dropped when full
      if (burst_end & ~rx_full) begin
        rx_mem[rx_wp_q] <= rx_word;
        rx_wp_q <= rx_wp_q + 2'd1;
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + 2'd1;
      end
      rx_cnt_q <= rx_cnt_q + {2'd0, burst_end & ~rx_full} -
                  {2'd0, rx_pop};
    end
  end

  // ***************************************************
  // Serial engine
  // ***************************************************
  always @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      div_q <= 12'h000;
      ph_q <= 7'd0;
      tsr_q <= 32'h00000000;
      rsr_q <= 32'h00000000;
      len_q <= 6'd1;
      cs_q <= 3'b111;
      keep_q <= 1'b0;
      first_in_q <= 1'b0;
      pend_q <= 1'b0;
      hcnt_q <= 4'd0;
      CS_N <= 3'b111;
      MOSI <= 1'b0;
      SERIAL_CLOCK_OUT <= 1'b0;
    end else begin
      // Half-bit divider
      if (state_q == ST_IDLE | tick) begin
        div_q <= 12'h000;
      end else begin
        div_q <= div_q + 12'h001;
      end
      // Delayed data-out update
      if (hcnt_q != 4'd0) begin
        hcnt_q <= hcnt_q - 4'd1;
        if (hcnt_q == 4'd1) begin
          MOSI <= pend_q;
        end
      end
      case (state_q)
        ST_IDLE: begin
          SERIAL_CLOCK_OUT <= cntl0_q[`USM_C0_INV];
          if (start) begin
            len_q <= ld_len;
            tsr_q <= ld_data;
            rsr_q <= 32'h00000000;
            cs_q <= ld_cs;
            keep_q <= tx_head[32];
            CS_N <= ld_cs;
            MOSI <= omsb ? ld_data[31] : ld_data[0];
            first_in_q <= post;
            ph_q <= 7'd0;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tick) begin
            ph_q <= ph_q + 7'd1;
            if (ph_q == 7'd1) begin
              ph_q <= 7'd0;
              state_q <= ST_SHIFT;
            end
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            SERIAL_CLOCK_OUT <= lvl_new;
            if (in_edge) begin
              if (first_in_q) begin
                first_in_q <= 1'b0;
              end else begin
                rsr_q <= rx_next;
              end
            end
            if (out_edge & (ph_q != 7'd0)) begin
              tsr_q <= omsb ? {tsr_q[30:0], 1'b0} : {1'b0, tsr_q[31:1]};
              if (hold == 4'd0) begin
                MOSI <= omsb ? tsr_q[30] : tsr_q[1];
              end else begin
                pend_q <= omsb ? tsr_q[30] : tsr_q[1];
                hcnt_q <= hold;
              end
            end
            ph_q <= ph_q + 7'd1;
            if (ph_q == shift_halves - 7'd1) begin
              ph_q <= 7'd0;
              state_q <= ST_TAIL;
            end
          end
        end
        ST_TAIL: begin
          if (tick) begin
            ph_q <= ph_q + 7'd1;
            if (burst_end) begin
              ph_q <= 7'd0;
              if (keep_q) begin
                state_q <= ST_IDLE;
              end else begin
                CS_N <= 3'b111;
                state_q <= ST_CSHI;
              end
            end
          end
        end
        ST_CSHI: begin
          CS_N <= 3'b111;
          if (tick) begin
            ph_q <= ph_q + 7'd1;
            if (ph_q == cshi_halves - 7'd1) begin
              ph_q <= 7'd0;
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          CS_N <= 3'b111;
        end
      endcase
    end
  end

  // ***************************************************
  // Interrupt line
  // ***************************************************
  always @(posedge CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (cntl1_q[`USM_C1_TXIE] & tx_empty) |
             (cntl1_q[`USM_C1_DNIE] & tx_empty &
              (state_q == ST_IDLE));
    end
  end

endmodule

// [testbench/usm_properties.sv]
`timescale 1ns/10ps
// ****
// Port checker
// ****
module usm_properties (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire SERIAL_CLOCK_OUT,
  input wire [2:0] CS_N
);
  reg wr_seen_q;
  wire cs_idle = &CS_N;
  // Notes the first register write after reset
  always @(posedge CLK) begin
    if (RST) wr_seen_q <= 1'b0;
    else if (PSEL && PENABLE && PREADY && PWRITE) wr_seen_q <= 1'b1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_acc_start; PSEL && PENABLE && !$past(PENABLE); endsequence
  sequence s_cs_drop; $fell(cs_idle); endsequence
  sequence s_cs_lift; $rose(cs_idle); endsequence
  a_ready_wait: assert property (s_acc_start |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read not zero");
  a_idle_before_en: assert property (!wr_seen_q |-> cs_idle)
    else $error("select before any setup");
  a_cs_setup: assert property (s_cs_drop |->
    $stable(SERIAL_CLOCK_OUT)[*2])
    else $error("clock moved in select setup");
  a_tail_still: assert property (s_cs_lift |->
    $stable(SERIAL_CLOCK_OUT))
    else $error("clock moved at select release");
  a_cs_high_min: assert property (s_cs_lift |-> cs_idle[*2])
    else $error("select high too short");
  a_cs_clk_apart: assert property ($changed(CS_N) |->
    $stable(SERIAL_CLOCK_OUT))
    else $error("select and clock moved together");
  a_idle_level: assert property (cs_idle && $past(cs_idle)
    && !$past(PREADY) && !$past(PREADY, 2) |-> $stable(SERIAL_CLOCK_OUT))
    else $error("clock moved while idle");
endmodule

bind usm_master usm_properties chk_u (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT), .CS_N(CS_N));

// [testbench/usm_spi_slave.sv]
`timescale 1ns/10ps
// ****
// Serial slave model
// ****
module usm_spi_slave (
  input wire CLK,
  input wire [2:0] cs_n,
  input wire sclk,
  input wire mosi,
  input wire out_rise,
  input wire [31:0] word,
  output reg miso,
  output reg [31:0] cap,
  output reg [5:0] nbits
);
  reg sclk_p;
  reg sel_p;
  reg [31:0] sh;
  wire sel = ~&cs_n;
  wire rise = sclk & ~sclk_p;
  wire fall = ~sclk & sclk_p;
  initial begin
    {sclk_p, sel_p, miso, cap, nbits, sh} = '0;
  end
  // Samples on the in edge, changes on the out edge, MSB first
  always @(posedge CLK) begin
    sclk_p <= sclk;
    sel_p <= sel;
    if (!sel) miso <= ~miso; // Released line keeps moving
    else if (!sel_p) begin
      sh <= word << 1;
      miso <= word[31];
      cap <= 32'h0;
      nbits <= 6'h0;
    end else if (out_rise ? fall : rise) begin
      cap <= {cap[30:0], mosi};
      nbits <= nbits + 6'h1;
    end else if ((out_rise ? rise : fall) && nbits != 6'h0) begin
      miso <= sh[31];
      sh <= sh << 1;
    end
  end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/10ps
`include "usm_defines.vh"
// ****
// Bench top
// ****
module testbench;
  reg CLK, RST, PSEL, PENABLE, PWRITE, out_rise, sclk_p, csi_p, er;
  reg [7:0] PADDR;
  reg [31:0] PWDATA, rd;
  wire [31:0] PRDATA, cap;
  wire PREADY, PSLVERR, MISO, MOSI, SERIAL_CLOCK_OUT, IRQ;
  wire [2:0] CS_N;
  wire [5:0] nbits;
  int n_mismatch, checked, gap, half, hi, last_hi, rises, i, m, n, r0;
  localparam logic [31:0] SW = 32'hc5a396e1;
  localparam logic [31:0] TD = 32'h9b3ce4d7;
  usm_master dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .MISO(MISO), .MOSI(MOSI),
    .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT), .CS_N(CS_N), .IRQ(IRQ));
  usm_spi_slave slv_u (.CLK(CLK), .cs_n(CS_N), .sclk(SERIAL_CLOCK_OUT),
    .mosi(MOSI), .out_rise(out_rise), .word(SW), .miso(MISO), .cap(cap),
    .nbits(nbits));
  initial begin
    CLK = 0;
    forever #12.5 CLK = ~CLK;
  end
  // Half bit, select high run and select release counts
  always @(posedge CLK) begin
    sclk_p <= SERIAL_CLOCK_OUT;
    if (SERIAL_CLOCK_OUT !== sclk_p) begin
      if (!(&CS_N)) half <= gap;
      gap <= 1;
    end else gap <= gap + 1;
    if (&CS_N) hi <= hi + 1;
    else begin
      if (hi > 0) last_hi <= hi;
      hi <= 0;
    end
    csi_p <= &CS_N;
    if ((&CS_N) && !csi_p) rises <= rises + 1;
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `USM_A_STAT, 32'h0);
      k++;
    end while ((rd[`USM_ST_BUSY] !== 1'b0 || rd[`USM_ST_TXE] !== 1'b1)
      && k < 100);
    if (k >= 100) n_mismatch++;
  endtask
  task wait_irq;
    int k;
    for (k = 0; k < 500 && IRQ !== 1'b1; k++) @(posedge CLK);
    if (k >= 500) n_mismatch++;
  endtask
  function logic [31:0] rev(input logic [31:0] v, input int w);
    rev = 32'h0;
    for (int j = 0; j < w; j++) rev[j] = v[w-1-j];
  endfunction
  function logic [31:0] c0(input logic [11:0] s, input logic o,
    input logic v, input logic b, input logic [5:0] l);
    c0 = {s, 3'b110, 6'b000001, ~o, 1'b0, o, v, b, l};
  endfunction
  task test_done;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog for a hung wait
  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    test_done;
  end
  // Test sequence
  initial begin
    {PSEL, PENABLE, PWRITE, out_rise, sclk_p, csi_p, er} = '0;
    PADDR = 8'h0; PWDATA = 32'h0; rd = 32'h0;
    {n_mismatch, checked, gap, half, hi, last_hi, rises} = '0;
    RST = 1;
    repeat (4) @(posedge CLK);
    RST <= 0;
    rdc(`USM_A_CNTL0, `USM_C0_RST);
    rdc(`USM_A_CNTL1, 32'h0);
    rdc(`USM_A_STAT, 32'h0000000a);
    rdc(8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test reset done");
    for (i = 0; i < 5; i++) wr(`USM_A_TXEND, 32'h10 + i);
    repeat (20) @(posedge CLK);
    chk({29'h0, CS_N}, 32'h7);
    rdc(`USM_A_STAT, 32'h0000040c);
    wr(`USM_A_CNTL1, 32'h00000300);
    wr(`USM_A_CNTL0, c0(12'h1, 1'b0, 1'b0, 1'b1, 6'd8));
    wait_idle;
    rdc(`USM_A_STAT, 32'h00004012);
    chk({31'h0, last_hi >= 16 && last_hi <= 19}, 32'h1);
    for (i = 0; i < 4; i++) rdc(`USM_A_RXDATA, rev(SW >> 24, 8));
    $display("test fifo done");
    for (m = 0; m < 4; m++) begin
      n = (m == 0) ? 8 : (m == 1) ? 32 : (m == 2) ? 1 : 13;
      out_rise <= m[0];
      wr(`USM_A_CNTL1, {30'h0, m[1], 1'b0});
      wr(`USM_A_CNTL0, c0(m + 1, m[0], m[1], m[0] ^ m[1], n));
      wr(`USM_A_TXEND, TD);
      wait_idle;
      rdc(`USM_A_RXDATA, m[1] ? SW >> (32 - n) : rev(SW >> (32 - n), n));
      chk(cap & (32'hffffffff >> (32 - n)),
        (m[0] ^ m[1]) ? TD & (32'hffffffff >> (32 - n)) : rev(TD, n));
      chk({26'h0, nbits}, n);
      chk(half, m + 2);
      chk({31'h0, SERIAL_CLOCK_OUT}, {31'h0, m[1]});
    end
    $display("test modes done");
    out_rise <= 0;
    wr(`USM_A_CNTL1, 32'h00000002);
    wr(`USM_A_CNTL0, c0(12'h1, 1'b0, 1'b0, 1'b1, 6'd8) | 32'h4000);
    wr(`USM_A_TXEND, 32'h1f123456);
    wait_idle;
    chk({26'h0, nbits}, 32'd24);
    chk(cap & 32'h00ffffff, 32'h00123456);
    rdc(`USM_A_RXDATA, SW >> 8);
    wr(`USM_A_CNTL0, (c0(12'h7, 1'b0, 1'b0, 1'b1, 6'd8) & ~32'h400) |
      32'h13000);
    wr(`USM_A_TXEND, TD);
    wait_idle;
    chk(cap & 32'hff, TD & 32'hff);
    rdc(`USM_A_RXDATA, (SW >> 23) & 32'hff);
    $display("test width and post done");
    wr(`USM_A_CNTL1, 32'h00000080);
    wr(`USM_A_CNTL0, c0(12'h3, 1'b0, 1'b0, 1'b1, 6'd8));
    r0 = rises;
    wr(`USM_A_TXHOLD, 32'ha5);
    wr(`USM_A_TXEND, 32'h3c);
    repeat (2) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    wait_irq;
    apb(1'b0, `USM_A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    wr(`USM_A_CNTL1, 32'h00000040);
    repeat (2) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    wait_idle;
    repeat (4) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h1);
    chk(rises - r0, 1);
    chk(cap & 32'hffff, 32'ha53c);
    rdc(`USM_A_STAT, 32'h00002002);
    $display("test stream done");
    test_done;
  end
endmodule
